// File: hw/dual_ff.sv
`timescale 1ns/1ps
// Sampled model: channel pins are synchronous inputs taken at MCLK; set and clear
// act combinationally on the outputs so they override without waiting for an edge.
module dual_ff
   import dual_ff_pkg::*;
(
   input  wire logic     MCLK,
   input  wire logic     RSTN,
   input  wire logic     CE,
   input  wire chan_in_t CH_IN  [CHANNELS],
   output chan_out_t     CH_OUT [CHANNELS]
);
   logic rst_meta_q;
   logic rst_n_q;

   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta_q <= 1'b0;
         rst_n_q    <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q    <= rst_meta_q;
      end
   end

   // Pin combination seen by one channel; the override cases win over the clock
   typedef enum {
      MODE_RUN,
      MODE_SET,
      MODE_CLEAR,
      MODE_BOTH
   } pin_mode_t;

   // Decode of set and clear, shared by the state update and the output drive
   function automatic pin_mode_t pin_mode(input chan_in_t pins);
      pin_mode_t mode;
      mode = MODE_RUN;
      if (!pins.async_set_n && !pins.async_clear_n) begin
         mode = MODE_BOTH;
      end else if (!pins.async_set_n) begin
         mode = MODE_SET;
      end else if (!pins.async_clear_n) begin
         mode = MODE_CLEAR;
      end
      return mode;
   endfunction

   // A channel clock edge is a high sample followed by a low one
   function automatic logic falling(input logic prev, input logic now);
      return prev && !now;
   endfunction

   // Output pair for a pin mode; overrides act at once, without an edge
   function automatic chan_out_t drive_pair(input pin_mode_t mode, input logic held);
      chan_out_t pair;
      pair.q   = held;
      pair.q_n = ~held;
      case (mode)
         MODE_SET: begin
            pair.q   = 1'b1;
            pair.q_n = 1'b0;
         end
         MODE_CLEAR: begin
            pair.q   = 1'b0;
            pair.q_n = 1'b1;
         end
         MODE_BOTH: begin
            // Both high is the one case in which the pair is not complementary
            pair.q   = 1'b1;
            pair.q_n = 1'b1;
         end
         MODE_RUN: begin
            pair.q   = held;
            pair.q_n = ~held;
         end
         default: begin
            pair.q   = held;
            pair.q_n = ~held;
         end
      endcase
      return pair;
   endfunction

   // Next stored value; an edge during an override is refused
   function automatic logic next_held(input pin_mode_t mode,
                                      input logic      fall,
                                      input logic      data,
                                      input logic      held);
      logic nxt;
      nxt = held;
      case (mode)
         MODE_SET:   nxt = 1'b1;
         MODE_CLEAR: nxt = 1'b0;
         // The both-low state is not stored; the release state is left to history
         MODE_BOTH:  nxt = held;
         MODE_RUN:   nxt = fall ? data : held;
         default:    nxt = held;
      endcase
      return nxt;
   endfunction

   logic [CHANNELS-1:0] held_output_value_q;
   logic [CHANNELS-1:0] clk_prev_q;

   for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
      pin_mode_t mode;
      logic      fall;
      logic      held_output_value_d;

      assign mode                = pin_mode(CH_IN[i]);
      assign fall                = falling(clk_prev_q[i], CH_IN[i].clk);
      assign held_output_value_d = next_held(mode, fall, CH_IN[i].data,
                                             held_output_value_q[i]);

      // The previous clock level restarts high, so a low pin at release counts as a falling edge
      always_ff @(posedge MCLK or negedge rst_n_q) begin
         if (!rst_n_q) begin
            clk_prev_q[i] <= LINK_IDLE;
         end else if (CE) begin
            clk_prev_q[i] <= CH_IN[i].clk;
         end
      end

      always_ff @(posedge MCLK or negedge rst_n_q) begin
         if (!rst_n_q) begin
            held_output_value_q[i] <= HELD_RESET;
         end else if (CE) begin
            held_output_value_q[i] <= held_output_value_d;
         end
      end

      // Overrides bypass the flop, so they act even while reset or frozen
      assign CH_OUT[i] = drive_pair(mode, held_output_value_q[i]);

      AST_SET_FORCE: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (!CH_IN[i].async_set_n && CH_IN[i].async_clear_n) |-> (CH_OUT[i].q && !CH_OUT[i].q_n))
         else $error("set did not force outputs");
      AST_CLR_FORCE: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CH_IN[i].async_set_n && !CH_IN[i].async_clear_n) |-> (!CH_OUT[i].q && CH_OUT[i].q_n))
         else $error("clear did not force outputs");
      AST_BOTH_LOW: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (!CH_IN[i].async_set_n && !CH_IN[i].async_clear_n) |-> (CH_OUT[i].q && CH_OUT[i].q_n))
         else $error("both low did not drive both high");
      AST_SAMPLE: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CE && fall && CH_IN[i].async_set_n && CH_IN[i].async_clear_n)
         ##1 (CH_IN[i].async_set_n && CH_IN[i].async_clear_n)
         |-> CH_OUT[i].q == $past(CH_IN[i].data))
         else $error("falling edge did not capture data");
      AST_COMPL: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CH_IN[i].async_set_n || CH_IN[i].async_clear_n) |-> (CH_OUT[i].q != CH_OUT[i].q_n))
         else $error("outputs not complementary");
      AST_HOLD: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CH_IN[i].async_set_n && CH_IN[i].async_clear_n && !(CE && fall))
         ##1 (CH_IN[i].async_set_n && CH_IN[i].async_clear_n) |-> $stable(CH_OUT[i].q))
         else $error("output changed without falling edge");
      AST_WAKE: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CE && fall && CH_IN[i].data && CH_IN[i].async_set_n && CH_IN[i].async_clear_n)
         ##1 CH_IN[i].async_clear_n |-> CH_OUT[i].q)
         else $error("wake-up edge did not raise output");
      AST_FREEZE: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         !CE |=> $stable(held_output_value_q[i]))
         else $error("state moved with enable low");
      AST_EDGE_FREEZE: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         !CE |=> $stable(clk_prev_q[i]))
         else $error("clock history moved with enable low");
      AST_HELD_SET: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CE && !CH_IN[i].async_set_n && CH_IN[i].async_clear_n) |=> held_output_value_q[i])
         else $error("set was not stored");
      AST_HELD_CLR: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CE && CH_IN[i].async_set_n && !CH_IN[i].async_clear_n) |=> !held_output_value_q[i])
         else $error("clear was not stored");
      AST_BOTH_KEEP: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CE && !CH_IN[i].async_set_n && !CH_IN[i].async_clear_n)
         |=> $stable(held_output_value_q[i]))
         else $error("both low changed the stored value");
      AST_TRUE_HELD: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CH_IN[i].async_set_n && CH_IN[i].async_clear_n)
         |-> (CH_OUT[i].q == held_output_value_q[i]))
         else $error("true output differs from stored value");
      AST_REFUSE_EDGE: assert property (@(posedge MCLK) disable iff (!rst_n_q)
         (CE && fall && CH_IN[i].data && CH_IN[i].async_set_n && !CH_IN[i].async_clear_n)
         |=> !held_output_value_q[i])
         else $error("edge taken while clear low");
   end
endmodule

// File: common/dual_ff_pkg.sv
package dual_ff_pkg;
   localparam int unsigned CHANNELS     = 2;
   localparam logic        HELD_RESET   = 1'h0;
   localparam logic        LINK_IDLE    = 1'h1;

   typedef struct packed {
      logic clk;
      logic data;
      logic async_set_n;
      logic async_clear_n;
   } chan_in_t;

   typedef struct packed {
      logic q;
      logic q_n;
   } chan_out_t;
endpackage

// File: bench/far_logic.sv
`timescale 1ns/1ps
module far_logic
   import dual_ff_pkg::*;
(
   input  wire logic     clk_sys,
   input  wire chan_in_t want,
   output chan_in_t      pins = 4'hB
);
   // Moves only on the falling system edge, clear of the sampling edge
   always @(negedge clk_sys) pins <= want;
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench
   import dual_ff_pkg::*;
;
   logic      MCLK = 1'h0;
   logic      RSTN = 1'h0;
   logic      CE = 1'h1;
   int        fails = 0;
   int        num_checks = 0;
   chan_in_t  want [CHANNELS];
   chan_in_t  pins [CHANNELS];
   chan_out_t outs [CHANNELS];
   initial forever #20 MCLK = ~MCLK;
   for (genvar i = 0; i < CHANNELS; i++) begin : g_far
      far_logic far (.clk_sys(MCLK), .want(want[i]), .pins(pins[i]));
   end
   dual_ff uut (.MCLK(MCLK), .RSTN(RSTN), .CE(CE), .CH_IN(pins), .CH_OUT(outs));
   task tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task check_out(input int ch, input chan_out_t exp);
      num_checks++;
      if (outs[ch] !== exp) begin
         fails++;
         $display("mismatch ch%0d outputs expected %b seen %b", ch, exp, outs[ch]);
      end
   endtask
   // Bits are clk, data, set_n, clear_n; three system edges cover the registered path
   task apply(input int ch, input logic [3:0] v, input chan_out_t exp);
      #1 want[ch] = chan_in_t'(v);
      repeat (3) @(negedge MCLK);
      check_out(ch, exp);
   endtask
   task scen_edges(input int c);
      apply(c, 4'hF, 2'h1);
      apply(c, 4'h7, 2'h2);
      apply(c, 4'hB, 2'h2);
      apply(c, 4'h3, 2'h1);
      $display("test edges channel %0d done", c);
   endtask
   task scen_overrides(input int c);
      apply(c, 4'h1, 2'h2);
      apply(c, 4'h2, 2'h1);
      apply(c, 4'h0, 2'h3);
      apply(c, 4'hF, 2'h1);
      apply(c, 4'h6, 2'h1);
      apply(c, 4'hF, 2'h1);
      $display("test overrides channel %0d done", c);
   endtask
   // Data held high, a falling wake line sets, a clear pulse returns to standby
   task scen_wake(input int c);
      apply(c, 4'hE, 2'h1);
      apply(c, 4'hF, 2'h1);
      apply(c, 4'h7, 2'h2);
      apply(c, 4'hF, 2'h2);
      apply(c, 4'hE, 2'h1);
      apply(c, 4'hF, 2'h1);
      $display("test wake channel %0d done", c);
   endtask
   // The edge seen while frozen is taken once the enable returns
   task scen_freeze(input int c);
      CE = 1'h0;
      apply(c, 4'h7, 2'h1);
      apply(c, 4'h5, 2'h2);
      apply(c, 4'h7, 2'h1);
      CE = 1'h1;
      apply(c, 4'h7, 2'h2);
      apply(c, 4'hF, 2'h2);
      $display("test freeze channel %0d done", c);
   endtask
   task scen_reset_mid;
      RSTN = 1'h0;
      repeat (2) @(negedge MCLK);
      check_out(0, 2'h1);
      check_out(1, 2'h1);
      RSTN = 1'h1;
      repeat (3) @(negedge MCLK);
      check_out(0, 2'h1);
      check_out(1, 2'h1);
      apply(0, 4'h7, 2'h2);
      check_out(1, 2'h1);
      $display("test mid-run reset done");
   endtask
   initial begin
      #20000;
      fails++;
      tally_and_finish;
   end
   initial begin
      for (int i = 0; i < CHANNELS; i++) want[i] = 4'hB;
      repeat (6) @(negedge MCLK);
      RSTN = 1'h1;
      repeat (3) @(negedge MCLK);
      for (int c = 0; c < CHANNELS; c++) begin
         scen_edges(c);
         scen_overrides(c);
         scen_wake(c);
         scen_freeze(c);
         if (c == 0) check_out(1, 2'h1);
      end
      scen_reset_mid;
      tally_and_finish;
   end
endmodule
